// *** hdl/spi_byte_pkg.sv ***
// Package for the SPI byte buffer path: register map, flag layout, timing.
// Assumes a 32-bit register port and a 100 MHz core clock.
package spi_byte_pkg;
	localparam logic [7:0] TX_BYTE_OFFSET = 8'h0c;
	localparam logic [7:0] RX_BYTE_OFFSET = 8'h10;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] CONTROL_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h24;
	localparam int STATUS_TXE_BIT = 0;
	localparam int STATUS_RXF_BIT = 1;
	localparam int STATUS_ACTIVE_BIT = 2;
	localparam int CONTROL_AUTO_READ_BIT = 5;
	localparam int CONTROL_LSB_FIRST_BIT = 0;
	localparam int IRQ_TX_BIT = 0;
	localparam int IRQ_RX_BIT = 1;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [3:0] DIVIDER_RESET = 4'h4;
	localparam int CORE_CLK_MHZ = 100;
	localparam int SERIAL_HALF_NS = 20;
	localparam int SERIAL_HALF_CYCLES =
		(SERIAL_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} reg_req_t;
	typedef struct packed {
		logic lsbFirst;
		logic autoRead;
	} ctrl_t;
endpackage

// *** hdl/spi_sync.sv ***
// Two flip-flop synchroniser for one level from outside the core clock.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ns
module spi_sync (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic async,
	output logic      synced
);
	logic meta;
	logic next_meta;
	logic next_synced;
	always_comb begin
		next_meta = rstn ? async : 1'b0;
		next_synced = rstn ? meta : 1'b0;
	end
	always_ff @(posedge core_clk) begin
		meta <= next_meta;
		synced <= next_synced;
	end
endmodule

// *** hdl/spi_shifter.sv ***
// Eight-bit serial shifter, mode 0, master side.
// Assumes a load pulse only while idle; reports done for one cycle.
`timescale 1ns/1ns
module spi_shifter #(
	parameter int HALF = spi_byte_pkg::SERIAL_HALF_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       load,
	input  wire logic [7:0] loadByte,
	input  wire logic       lsbFirst,
	input  wire logic       serialIn,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rxByte,
	output logic            sclk,
	output logic            serialOut
);
	logic [7:0] txShift;
	logic [7:0] next_txShift;
	logic [7:0] next_rxByte;
	logic [3:0] bitCount;
	logic [3:0] next_bitCount;
	logic [7:0] tick;
	logic [7:0] next_tick;
	logic next_busy;
	logic next_done;
	logic next_sclk;
	logic next_serialOut;
	always_comb begin
		next_txShift = txShift;
		next_rxByte = rxByte;
		next_bitCount = bitCount;
		next_tick = tick;
		next_busy = busy;
		next_done = 1'b0;
		next_sclk = sclk;
		next_serialOut = serialOut;
		if (load && !busy) begin
			next_busy = 1'b1;
			next_tick = 8'h00;
			next_bitCount = 4'h0;
			next_serialOut = lsbFirst ? loadByte[0] : loadByte[7];
			next_txShift = lsbFirst ? {1'b0, loadByte[7:1]}
				: {loadByte[6:0], 1'b0};
		end else if (busy) begin
			if (tick == 8'(HALF - 1)) begin
				next_tick = 8'h00;
				next_sclk = !sclk;
				if (!sclk) begin
					// Sample on the rising edge of the serial clock.
					next_rxByte = lsbFirst ? {serialIn, rxByte[7:1]}
						: {rxByte[6:0], serialIn};
				end else begin
					next_bitCount = bitCount + 4'h1;
					next_serialOut = lsbFirst ? txShift[0] : txShift[7];
					next_txShift = lsbFirst ? {1'b0, txShift[7:1]}
						: {txShift[6:0], 1'b0};
					if (bitCount == 4'h7) begin
						next_busy = 1'b0;
						next_done = 1'b1;
					end
				end
			end else begin
				next_tick = tick + 8'h01;
			end
		end
		if (!rstn) begin
			next_txShift = 8'h00;
			next_rxByte = 8'h00;
			next_bitCount = 4'h0;
			next_tick = 8'h00;
			next_busy = 1'b0;
			next_sclk = 1'b0;
			next_serialOut = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		txShift <= next_txShift;
		rxByte <= next_rxByte;
		bitCount <= next_bitCount;
		tick <= next_tick;
		busy <= next_busy;
		done <= next_done;
		sclk <= next_sclk;
		serialOut <= next_serialOut;
	end
endmodule

// *** hdl/spi_byte_buffer_path.sv ***
// Transmit and receive byte holding registers of a general SPI master.
// Assumes a one-cycle strobe register port and an external peripheral on
// the serial pins; the serial input comes from another domain.
//
// Behaviour
// - Writing transmit byte while empty flag is one starts a transfer.
// - Byte written to idle shifter moves in; empty flag sets again.
// - Byte written during shifting waits, loads when shifter frees.
// - Each byte end captures serial input and sets receive full flag.
// - Receive byte loads while full is clear or read that cycle; pending loads on clear.
// - Receive read clears full flag; auto-read also clears empty flag.
// - Empty flag resets to one, cleared by write; full resets zero.
`timescale 1ns/1ns
module spi_byte_buffer_path #(
	parameter int HALF = spi_byte_pkg::SERIAL_HALF_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        write,
	input  wire logic        read,
	output logic      [31:0] rdata,
	output logic             irq,
	input  wire logic        serialIn,
	output logic             sclk,
	output logic             serialOut
);
	spi_byte_pkg::reg_req_t req;
	spi_byte_pkg::ctrl_t ctrl;
	spi_byte_pkg::ctrl_t next_ctrl;
	logic [7:0] txHold;
	logic [7:0] next_txHold;
	logic [7:0] rxHold;
	logic [7:0] next_rxHold;
	logic [7:0] rxPendByte;
	logic [7:0] next_rxPendByte;
	logic transmit_empty_flag;
	logic next_transmit_empty_flag;
	logic receive_full_flag;
	logic next_receive_full_flag;
	logic txPending;
	logic next_txPending;
	logic rxPending;
	logic next_rxPending;
	logic [1:0] irqStatus;
	logic [1:0] next_irqStatus;
	logic [1:0] irqMask;
	logic [1:0] next_irqMask;
	logic [31:0] next_rdata;
	logic serialInSync;
	logic shiftBusy;
	logic shiftDone;
	logic [7:0] shiftRx;
	logic shiftLoad;
	logic txWrite;
	logic rxRead;
	logic wasEmpty;
	logic wasFull;

	assign req = '{addr: addr, wdata: wdata, write: write, read: read};
	assign txWrite = req.write && req.addr == spi_byte_pkg::TX_BYTE_OFFSET;
	assign rxRead = req.read && req.addr == spi_byte_pkg::RX_BYTE_OFFSET;
	// Pending byte enters the shifter in the first cycle that it is idle.
	assign shiftLoad = txPending && !shiftBusy;

	spi_sync serialSync (
		.core_clk(core_clk),
		.rstn    (rstn),
		.async   (serialIn),
		.synced  (serialInSync)
	);

	spi_shifter #(
		.HALF(HALF)
	) shifter (
		.core_clk (core_clk),
		.rstn     (rstn),
		.load     (shiftLoad),
		.loadByte (txHold),
		.lsbFirst (ctrl.lsbFirst),
		.serialIn (serialInSync),
		.busy     (shiftBusy),
		.done     (shiftDone),
		.rxByte   (shiftRx),
		.sclk     (sclk),
		.serialOut(serialOut)
	);

	logic       ctrlWrite;
	logic       maskWrite;
	logic       irqClearWrite;
	logic [1:0] irqEvent;
	logic [1:0] irqClear;

	assign ctrlWrite =
		req.write && req.addr == spi_byte_pkg::CONTROL_OFFSET;
	assign maskWrite =
		req.write && req.addr == spi_byte_pkg::IRQ_MASK_OFFSET;
	assign irqClearWrite =
		req.write && req.addr == spi_byte_pkg::IRQ_STATUS_OFFSET;

	// Control group. Changing the bit order in mid-byte corrupts that byte,
	// so software only touches it while the shifter is idle.
	always_comb begin
		next_ctrl = ctrl;
		if (ctrlWrite) begin
			next_ctrl.autoRead =
				req.wdata[spi_byte_pkg::CONTROL_AUTO_READ_BIT];
			next_ctrl.lsbFirst =
				req.wdata[spi_byte_pkg::CONTROL_LSB_FIRST_BIT];
		end
		if (!rstn) begin
			next_ctrl = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		ctrl <= next_ctrl;
	end

	// Transmit group: holding byte, pending mark and empty flag.
	always_comb begin
		next_txHold = txHold;
		next_txPending = txPending;
		next_transmit_empty_flag = transmit_empty_flag;
		wasEmpty = 1'b0;
		// The auto-read clear comes first so that a load in the same cycle
		// still sets the flag: the hardware event wins over the clear.
		if (rxRead && ctrl.autoRead) begin
			next_transmit_empty_flag = 1'b0;
		end
		// A write while a byte waits overwrites the waiting byte; software avoids it.
		if (txWrite) begin
			next_txHold = req.wdata[7:0];
			next_txPending = 1'b1;
			next_transmit_empty_flag = 1'b0;
		end
		if (shiftLoad) begin
			next_txPending = txWrite;
			if (!txWrite) begin
				next_transmit_empty_flag = 1'b1;
				wasEmpty = 1'b1;
			end
		end
		if (!rstn) begin
			next_txHold = spi_byte_pkg::HOLD_RESET;
			next_txPending = 1'b0;
			next_transmit_empty_flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		txHold <= next_txHold;
		txPending <= next_txPending;
		transmit_empty_flag <= next_transmit_empty_flag;
	end

	// Receive group. A byte finished while full waits in rxPendByte; a
	// further byte finished before any read replaces the waiting one.
	always_comb begin
		next_rxHold = rxHold;
		next_rxPendByte = rxPendByte;
		next_receive_full_flag = receive_full_flag;
		next_rxPending = rxPending;
		wasFull = 1'b0;
		if (rxRead) begin
			next_receive_full_flag = 1'b0;
		end
		if (shiftDone) begin
			if (receive_full_flag && !rxRead) begin
				next_rxPendByte = shiftRx;
				next_rxPending = 1'b1;
			end else begin
				next_rxHold = shiftRx;
				next_receive_full_flag = 1'b1;
				wasFull = 1'b1;
			end
		end else if (rxPending && !receive_full_flag) begin
			next_rxHold = rxPendByte;
			next_rxPending = 1'b0;
			next_receive_full_flag = 1'b1;
			wasFull = 1'b1;
		end
		if (!rstn) begin
			next_rxHold = spi_byte_pkg::HOLD_RESET;
			next_rxPendByte = spi_byte_pkg::HOLD_RESET;
			next_receive_full_flag = 1'b0;
			next_rxPending = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		rxHold <= next_rxHold;
		rxPendByte <= next_rxPendByte;
		receive_full_flag <= next_receive_full_flag;
		rxPending <= next_rxPending;
	end

	// Interrupt group: sticky events, write-one-to-clear, level output.
	always_comb begin
		irqEvent = 2'b00;
		irqEvent[spi_byte_pkg::IRQ_TX_BIT] = wasEmpty;
		irqEvent[spi_byte_pkg::IRQ_RX_BIT] = wasFull;
		irqClear = 2'b00;
		if (irqClearWrite) begin
			irqClear = req.wdata[1:0];
		end
	end

	// An event in the same cycle as its clear wins, so none is lost.
	for (genvar i = 0; i < 2; i++) begin : gen_irq_bit
		assign next_irqStatus[i] =
			rstn && (irqEvent[i] || (irqStatus[i] && !irqClear[i]));
	end

	always_comb begin
		next_irqMask = irqMask;
		if (maskWrite) begin
			next_irqMask = req.wdata[1:0];
		end
		if (!rstn) begin
			next_irqMask = 2'b00;
		end
	end

	always_ff @(posedge core_clk) begin
		irqMask <= next_irqMask;
		irqStatus <= next_irqStatus;
	end

	assign irq = |(irqStatus & irqMask);

	// Read data stand for the one cycle after the strobe, zero otherwise.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (req.read) begin
			unique case (req.addr)
				spi_byte_pkg::TX_BYTE_OFFSET: next_rdata = {24'h00_0000, txHold};
				spi_byte_pkg::RX_BYTE_OFFSET: next_rdata = {24'h00_0000, rxHold};
				spi_byte_pkg::STATUS_OFFSET: begin
					next_rdata[spi_byte_pkg::STATUS_TXE_BIT] = transmit_empty_flag;
					next_rdata[spi_byte_pkg::STATUS_RXF_BIT] = receive_full_flag;
					next_rdata[spi_byte_pkg::STATUS_ACTIVE_BIT] =
						shiftBusy | txPending | receive_full_flag;
				end
				spi_byte_pkg::CONTROL_OFFSET: begin
					next_rdata[spi_byte_pkg::CONTROL_AUTO_READ_BIT] = ctrl.autoRead;
					next_rdata[spi_byte_pkg::CONTROL_LSB_FIRST_BIT] = ctrl.lsbFirst;
				end
				spi_byte_pkg::IRQ_STATUS_OFFSET: next_rdata[1:0] = irqStatus;
				spi_byte_pkg::IRQ_MASK_OFFSET: next_rdata[1:0] = irqMask;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		if (!rstn) begin
			next_rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		rdata <= next_rdata;
	end
endmodule

// *** tb/spi_byte_buffer_path_sva.sv ***
// Checker for the SPI byte buffer path, bound to its top module.
// Assumes the register map and reset values of the design package.
`timescale 1ns/1ns
module spi_byte_buffer_path_sva #(
	parameter int HALF = 2
) (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        write,
	input wire logic        read,
	input wire logic [31:0] rdata,
	input wire logic        irq,
	input wire logic        serialIn,
	input wire logic        sclk,
	input wire logic        serialOut
);
	localparam int START_MAX = 4 * HALF + 4;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	sequence txWrite;
		write && addr == spi_byte_pkg::TX_BYTE_OFFSET;
	endsequence
	sequence rxRead;
		read && addr == spi_byte_pkg::RX_BYTE_OFFSET;
	endsequence
	sequence statusRead;
		read && addr == spi_byte_pkg::STATUS_OFFSET;
	endsequence
	sequence holdRead;
		read && (addr == spi_byte_pkg::TX_BYTE_OFFSET ||
			addr == spi_byte_pkg::RX_BYTE_OFFSET);
	endsequence
	a_reset_quiet: assert property (
		$rose(rstn) |-> rdata == 0 && !irq && !sclk)
		else $error("outputs not quiet after reset");
	a_tx_starts: assert property (
		txWrite |-> ##[1:START_MAX] $rose(sclk))
		else $error("transmit write started no clock");
	a_upper_zero: assert property (
		holdRead |=> rdata[31:8] == 24'h00_0000)
		else $error("holding register upper bits not zero");
	a_rdata_idle: assert property (
		!read |=> rdata == 0)
		else $error("read data outside its cycle");
	a_rx_clears: assert property (
		rxRead ##2 statusRead |=> !rdata[spi_byte_pkg::STATUS_RXF_BIT])
		else $error("full flag not cleared by read");
	a_irq_falls: assert property (
		$fell(irq) |-> $past(write))
		else $error("interrupt dropped without a write");
	a_out_on_low: assert property (
		$changed(serialOut) |-> !sclk)
		else $error("serial output moved while clock high");
	a_bit_stable: assert property (
		$rose(sclk) |-> $stable(serialOut))
		else $error("serial output moved at clock rise");
endmodule
bind spi_byte_buffer_path spi_byte_buffer_path_sva #(.HALF(HALF)) chk_i (
	.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.write(write), .read(read), .rdata(rdata), .irq(irq),
	.serialIn(serialIn), .sclk(sclk), .serialOut(serialOut));

// *** tb/spi_peer.sv ***
// Behavioural SPI peripheral, mode 0, most significant bit first.
// Assumes the master idles its clock low and gives eight clocks a byte.
`timescale 1ns/1ns
module spi_peer (
	input  wire logic       sclk,
	input  wire logic       toPeer,
	input  wire logic [7:0] seed,
	output logic            fromPeer,
	output logic [7:0]      got,
	output logic [7:0]      frames
);
	logic [2:0] bitIdx;
	logic [7:0] shiftIn;
	logic [7:0] sendByte;
	logic       sawRise;
	initial begin
		sawRise = 1'b0;
		bitIdx = 3'd0;
		frames = 8'h00;
		got = 8'h00;
		shiftIn = 8'h00;
	end
	// Each frame answers a different byte so a stale capture is caught.
	assign sendByte = seed + frames;
	assign fromPeer = sendByte[3'd7 - bitIdx];
	always @(posedge sclk) begin
		shiftIn = {shiftIn[6:0], toPeer};
		sawRise = 1'b1;
	end
	// The unknown-to-low step of the clock at power-up is no real edge.
	always @(negedge sclk) begin
		if (sawRise) begin
			if (bitIdx == 3'd7) begin
				got = shiftIn;
				frames = frames + 8'h01;
			end
			bitIdx = bitIdx + 3'd1;
		end
	end
endmodule

// *** tb/test_spi_byte_buffer_path.sv ***
// Self-checking bench for the SPI byte buffer path and a peripheral model.
// Assumes the package register map; the peripheral never stalls.
`timescale 1ns/1ns
module test_spi_byte_buffer_path;
	localparam int HALF = 4;
	localparam logic [7:0] TXA = spi_byte_pkg::TX_BYTE_OFFSET;
	localparam logic [7:0] RXA = spi_byte_pkg::RX_BYTE_OFFSET;
	localparam logic [7:0] STA = spi_byte_pkg::STATUS_OFFSET;
	localparam logic [7:0] IST = spi_byte_pkg::IRQ_STATUS_OFFSET;
	logic        core_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        write;
	logic        read;
	logic [31:0] rdata;
	logic        irq;
	logic        serialIn;
	logic        sclk;
	logic        serialOut;
	logic [7:0]  seed;
	logic [7:0]  got;
	logic [7:0]  frames;
	logic [31:0] d;
	int          badCount;
	int          nTests;
	spi_byte_buffer_path #(.HALF(HALF)) dut (.core_clk(core_clk),
		.rstn(rstn), .addr(addr), .wdata(wdata), .write(write),
		.read(read), .rdata(rdata), .irq(irq), .serialIn(serialIn),
		.sclk(sclk), .serialOut(serialOut));
	spi_peer peer (.sclk(sclk), .toPeer(serialOut), .seed(seed),
		.fromPeer(serialIn), .got(got), .frames(frames));
	function automatic logic [31:0] expRx(logic [7:0] s, logic [7:0] n);
		return {24'h00_0000, 8'(s + n)};
	endfunction
	function automatic logic [7:0] rev8(logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		write <= 1'b1;
		@(posedge core_clk);
		write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		addr <= a;
		read <= 1'b1;
		@(posedge core_clk);
		read <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask
	task automatic waitFull();
		for (int k = 0; k < 100; k++) begin
			rd(STA);
			if (d[1] === 1'b1) break;
		end
	endtask
	task automatic xfer(input logic [31:0] statusAfter, input logic lsb);
		logic [31:0] w;
		logic [31:0] e;
		logic [7:0]  sent;
		w = $urandom;
		seed <= 8'($urandom);
		@(posedge core_clk);
		e = expRx(seed, frames);
		if (lsb)
			e = {24'h00_0000, rev8(e[7:0])};
		sent = lsb ? rev8(w[7:0]) : w[7:0];
		wr(TXA, w);
		repeat (3) @(negedge core_clk);
		chk({31'h0, irq}, 0);
		waitFull();
		chk({31'h0, irq}, 1);
		rd(IST);
		chk(d, 32'h0000_0003);
		rd(RXA);
		chk(d, e);
		rd(STA);
		chk(d & 32'h0000_0003, statusAfter);
		chk({24'h00_0000, got}, {24'h00_0000, sent});
		wr(IST, 32'h0000_0003);
		@(negedge core_clk);
		chk({31'h0, irq}, 0);
	endtask
	task automatic finishTest();
		$display("checks %0d, mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		finishTest();
	end
	initial begin
		logic [7:0] f0;
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		write = 1'b0;
		read = 1'b0;
		seed = 8'h00;
		badCount = 0;
		nTests = 0;
		d = $urandom(32'h0000_e913);
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		chk({31'h0, irq}, 0);
		rd(TXA);
		chk(d, 0);
		rd(RXA);
		chk(d, 0);
		rd(STA);
		chk(d & 32'h0000_0003, 1);
		rd(8'h30);
		chk(d, 0);
		wr(spi_byte_pkg::IRQ_MASK_OFFSET, 32'h0000_0002);
		repeat (3) xfer(1, 1'b0);
		f0 = frames;
		wr(TXA, 32'hffff_ffa5);
		@(posedge core_clk);
		rd(STA);
		chk(d & 32'h0000_0001, 1);
		wr(TXA, 32'h0000_005a);
		rd(STA);
		chk(d & 32'h0000_0001, 0);
		for (int k = 0; k < 300 && frames != 8'(f0 + 2); k++)
			@(posedge core_clk);
		repeat (2 * HALF) @(posedge core_clk);
		rd(RXA);
		chk(d, expRx(seed, f0));
		// The waiting byte reaches the holding register a cycle after the
		// full flag clears.
		@(posedge core_clk);
		rd(RXA);
		chk(d, expRx(seed, 8'(f0 + 1)));
		chk({24'h00_0000, got}, 32'h0000_005a);
		wr(IST, 32'h0000_0003);
		wr(spi_byte_pkg::CONTROL_OFFSET, 32'h0000_0001);
		xfer(1, 1'b1);
		wr(spi_byte_pkg::CONTROL_OFFSET, 32'h0000_0020);
		xfer(0, 1'b0);
		finishTest();
	end
endmodule
